// ===== imac_pkg.sv
// constants and types for the integer multiply-accumulate unit
//
// Contract
// - signed accumulate adds sign-extended product to upper:lower low words
// - opcode 011100 function 000001: unsigned accumulate, zero-extended
// - sum low word to lower, high word to upper, each sign-extended
// - accumulate latency and repeat depend on operand size; completion told
// - product writes sign-extended low 32 bits of product to destination
// - accumulators undefined after a product; nobody may rely on them
// - product of two 16-bit operands: latency 4, repeat every 2 cycles
// - product stalls 1 extra for 32x16, 2 extra for 32x32
// - one 32-bit word per instruction, opcode in six top bits
// - register fields: opcode, source a, source b, dest, shift, function
// - accumulates need zero dest and shift fields; no exceptions raised
// - accumulator reads wait until prior multiply or accumulate completes
package imac_pkg;
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int XLEN   = 64;
    localparam int REG_W  = 5;
    localparam int CNT_W  = 3;

    localparam int OPC_TOP   = 31;
    localparam int OPC_BOT   = 26;
    localparam int SRCA_TOP  = 25;
    localparam int SRCA_BOT  = 21;
    localparam int SRCB_TOP  = 20;
    localparam int SRCB_BOT  = 16;
    localparam int DST_TOP   = 15;
    localparam int DST_BOT   = 11;
    localparam int SHAMT_TOP = 10;
    localparam int SHAMT_BOT = 6;
    localparam int FN_TOP    = 5;
    localparam int FN_BOT    = 0;

    localparam logic [5:0] OPC_SPECIAL2 = 6'h1C;
    localparam logic [5:0] FN_SACC      = 6'h00;
    localparam logic [5:0] FN_UACC      = 6'h01;
    localparam logic [5:0] FN_PROD      = 6'h02;
    localparam logic [4:0] FIELD_ZERO   = 5'h00;

    localparam logic [CNT_W-1:0] LAT_BASE = 3'h4;
    localparam logic [CNT_W-1:0] REP_BASE = 3'h2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;

    typedef enum logic [1:0] {
        IMAC_OP_NONE,
        IMAC_OP_SACC,
        IMAC_OP_UACC,
        IMAC_OP_PROD
    } imac_op_t;
endpackage : imac_pkg

// ===== imac_size_if.sv
// operand-size classification carrier between core and classifier
`timescale 1ns/1ns
`default_nettype none
interface imac_size_if;
    logic [31:0] opa;
    logic [31:0] opb;
    logic        zero_ext;
    logic [1:0]  wide_cnt;
    modport core     (output opa, output opb, output zero_ext,
                      input wide_cnt);
    modport classify (input opa, input opb, input zero_ext,
                      output wide_cnt);
endinterface : imac_size_if
`default_nettype wire

// ===== imac_size_class.sv
// counts operands that need more than 16 bits
`timescale 1ns/1ns
`default_nettype none
module imac_size_class
    import imac_pkg::*;
(
    imac_size_if.classify sz // operands in, wide count out
);
    function automatic logic wide_f(input logic [WORD_W-1:0] v,
                                    input logic              zx);
        logic [WORD_W-HALF_W:0] top;
        top = v[WORD_W-1:HALF_W-1];
        // unsigned: any high bit set; signed: high bits not a sign copy
        if (zx) begin
            wide_f = |v[WORD_W-1:HALF_W];
        end else begin
            wide_f = !((&top) || !(|top));
        end
    endfunction : wide_f

    logic a_wide;
    logic b_wide;
    always_comb begin
        a_wide = wide_f(sz.opa, sz.zero_ext);
        b_wide = wide_f(sz.opb, sz.zero_ext);
        sz.wide_cnt = {1'b0, a_wide} + {1'b0, b_wide};
    end
endmodule : imac_size_class
`default_nettype wire

// ===== imac_unit.sv
// multiply and multiply-accumulate execution unit
`timescale 1ns/1ns
`default_nettype none
module imac_unit
    import imac_pkg::*;
(
    input  wire logic            clk_sys,        // core clock
    input  wire logic            nrst,           // async reset, low
    input  wire logic            issue_valid,    // instruction offered
    input  wire logic [31:0]     issue_instr,    // instruction word
    input  wire logic [XLEN-1:0] src_a_data,     // source a value
    input  wire logic [XLEN-1:0] src_b_data,     // source b value
    output logic                 issue_ready,    // instruction taken
    output logic                 stall_req,      // hold the pipeline
    output logic                 gpr_we,         // product write pulse
    output logic [REG_W-1:0]     gpr_waddr,      // product destination
    output logic [XLEN-1:0]      gpr_wdata,      // product value
    output logic [XLEN-1:0]      accumulator_upper, // upper accumulator
    output logic [XLEN-1:0]      accumulator_bottom, // lower accumulator
    input  wire logic            read_upper_accumulator, // read upper
    input  wire logic            read_lower_accumulator, // read lower
    output logic                 read_ready,     // read taken
    output logic                 read_valid,     // read data pulse
    output logic [XLEN-1:0]      read_data       // read data
);
    localparam int NSLOT = 2;

    logic [5:0]       opc_w;
    logic [5:0]       fn_w;
    logic [REG_W-1:0] dst_w;
    logic [REG_W-1:0] shamt_w;
    imac_op_t         op_w;
    logic             accept;
    logic             any_busy;
    logic             read_req;
    logic [CNT_W-1:0] lat_new;
    logic [CNT_W-1:0] rep_new;
    logic [CNT_W-1:0] rep_cnt_q;
    logic [WORD_W-1:0] prod_lo;
    logic signed [XLEN-1:0] sprod;
    logic [XLEN-1:0]  uprod;
    logic [XLEN-1:0]  acc_sum;
    logic [XLEN-1:0]  new_val;
    logic [CNT_W-1:0] cnt_q [NSLOT];
    logic [XLEN-1:0]  val_q [NSLOT];
    logic [REG_W-1:0] dst_q [NSLOT];
    logic             acc_q [NSLOT];
    logic             sel_q;

    imac_size_if sz_if ();
    imac_size_class u_size (.sz(sz_if.classify));

    // fixed field slicing, same for either byte order
    assign opc_w   = issue_instr[OPC_TOP:OPC_BOT];
    assign fn_w    = issue_instr[FN_TOP:FN_BOT];
    assign dst_w   = issue_instr[DST_TOP:DST_BOT];
    assign shamt_w = issue_instr[SHAMT_TOP:SHAMT_BOT];

    // malformed encodings are simply not taken: no exception path
    always_comb begin
        op_w = IMAC_OP_NONE;
        if (opc_w == OPC_SPECIAL2 && shamt_w == FIELD_ZERO) begin
            case (fn_w)
                FN_SACC: if (dst_w == FIELD_ZERO) op_w = IMAC_OP_SACC;
                FN_UACC: if (dst_w == FIELD_ZERO) op_w = IMAC_OP_UACC;
                FN_PROD: op_w = IMAC_OP_PROD;
                default: op_w = IMAC_OP_NONE;
            endcase
        end
    end

    assign sz_if.opa      = src_a_data[WORD_W-1:0];
    assign sz_if.opb      = src_b_data[WORD_W-1:0];
    assign sz_if.zero_ext = (op_w == IMAC_OP_UACC);

    assign any_busy = (cnt_q[0] != CNT_ZERO) || (cnt_q[1] != CNT_ZERO);
    assign lat_new  = LAT_BASE + {1'b0, sz_if.wide_cnt};
    // accumulates block until done so a chained one sees fresh sums
    assign rep_new  = (op_w == IMAC_OP_PROD)
                    ? REP_BASE + {1'b0, sz_if.wide_cnt} : lat_new;

    always_comb begin
        issue_ready = (rep_cnt_q == CNT_ZERO)
                    && (op_w == IMAC_OP_PROD || !any_busy);
    end
    assign accept   = issue_valid && issue_ready && (op_w != IMAC_OP_NONE);
    assign read_req = read_upper_accumulator || read_lower_accumulator;
    assign read_ready = !any_busy;
    assign stall_req  = (issue_valid && op_w != IMAC_OP_NONE && !issue_ready)
                      || (read_req && !read_ready);

    // arithmetic done at issue, result parked until the count expires
    always_comb begin
        prod_lo = src_a_data[WORD_W-1:0] * src_b_data[WORD_W-1:0];
        sprod   = $signed({{WORD_W{src_a_data[WORD_W-1]}},
                           src_a_data[WORD_W-1:0]})
                * $signed({{WORD_W{src_b_data[WORD_W-1]}},
                           src_b_data[WORD_W-1:0]});
        uprod   = {{WORD_W{1'b0}}, src_a_data[WORD_W-1:0]}
                * {{WORD_W{1'b0}}, src_b_data[WORD_W-1:0]};
        acc_sum = {accumulator_upper[WORD_W-1:0],
                   accumulator_bottom[WORD_W-1:0]}
                + ((op_w == IMAC_OP_UACC) ? uprod : XLEN'(sprod));
        new_val = (op_w == IMAC_OP_PROD)
                ? {{WORD_W{prod_lo[WORD_W-1]}}, prod_lo} : acc_sum;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rep_cnt_q <= CNT_ZERO;
        end else if (accept) begin
            // one less: the edge that sees zero already takes the next op
            rep_cnt_q <= rep_new - CNT_ONE;
        end else if (rep_cnt_q != CNT_ZERO) begin
            rep_cnt_q <= rep_cnt_q - CNT_ONE;
        end
    end

    // two slots suffice: latency exceeds repeat by at most two cycles
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sel_q <= 1'b0;
            for (int i = 0; i < NSLOT; i++) begin
                cnt_q[i] <= CNT_ZERO;
                val_q[i] <= '0;
                dst_q[i] <= FIELD_ZERO;
                acc_q[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < NSLOT; i++) begin
                if (accept && sel_q == i[0]) begin
                    // result registers on the edge that sees one
                    cnt_q[i] <= lat_new - CNT_ONE;
                    val_q[i] <= new_val;
                    dst_q[i] <= dst_w;
                    acc_q[i] <= (op_w != IMAC_OP_PROD);
                end else if (cnt_q[i] != CNT_ZERO) begin
                    cnt_q[i] <= cnt_q[i] - CNT_ONE;
                end
            end
            if (accept) begin
                sel_q <= !sel_q;
            end
        end
    end

    // completion: product to the register file, sum to the accumulators
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gpr_we             <= 1'b0;
            gpr_waddr          <= FIELD_ZERO;
            gpr_wdata          <= '0;
            accumulator_upper  <= '0;
            accumulator_bottom <= '0;
        end else begin
            gpr_we <= 1'b0;
            for (int i = 0; i < NSLOT; i++) begin
                if (cnt_q[i] == CNT_ONE && !acc_q[i]) begin
                    gpr_we    <= 1'b1;
                    gpr_waddr <= dst_q[i];
                    gpr_wdata <= val_q[i];
                end
                if (cnt_q[i] == CNT_ONE && acc_q[i]) begin
                    accumulator_upper  <= {{WORD_W{val_q[i][XLEN-1]}},
                                           val_q[i][XLEN-1:WORD_W]};
                    accumulator_bottom <= {{WORD_W{val_q[i][WORD_W-1]}},
                                           val_q[i][WORD_W-1:0]};
                end
            end
        end
    end
    // products leave the accumulators as they were; callers must not care

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            read_valid <= 1'b0;
            read_data  <= '0;
        end else begin
            read_valid <= read_req && read_ready;
            if (read_req && read_ready) begin
                read_data <= read_upper_accumulator
                           ? accumulator_upper : accumulator_bottom;
            end
        end
    end

    default clocking imac_cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence narrow_prod_s;
        accept && op_w == IMAC_OP_PROD && sz_if.wide_cnt == 2'h0;
    endsequence
    sequence mixed_prod_s;
        accept && op_w == IMAC_OP_PROD && sz_if.wide_cnt == 2'h1;
    endsequence
    sequence wide_prod_s;
        accept && op_w == IMAC_OP_PROD && sz_if.wide_cnt == 2'h2;
    endsequence

    // pipelined products may write in earlier cycles, so the narrow check looks only at the latency slot;
    // the 32x16 and 32x32 checks also require no write in the cycle before it
    prod_narrow_lat_a: assert property (
        narrow_prod_s |-> ##4 (gpr_we && gpr_waddr == $past(dst_w, 4)))
        else $error("narrow product not written after 4 cycles");
    prod_narrow_rep_a: assert property (
        narrow_prod_s |=> !accept ##1 (rep_cnt_q == CNT_ZERO))
        else $error("narrow product repeat is not 2 cycles");
    prod_mixed_lat_a: assert property (
        mixed_prod_s |-> ##5 gpr_we ##0 $past(gpr_we) == 1'b0)
        else $error("32x16 product not written after 5 cycles");
    prod_wide_lat_a: assert property (
        wide_prod_s |-> ##6 (gpr_we && !$past(gpr_we)))
        else $error("32x32 product not written after 6 cycles");
    prod_sext_a: assert property (
        gpr_we |-> gpr_wdata[XLEN-1:WORD_W] == {WORD_W{gpr_wdata[WORD_W-1]}})
        else $error("product result not sign-extended");
    acc_sext_a: assert property (
        accumulator_bottom[XLEN-1:WORD_W]
            == {WORD_W{accumulator_bottom[WORD_W-1]}}
        && accumulator_upper[XLEN-1:WORD_W]
            == {WORD_W{accumulator_upper[WORD_W-1]}})
        else $error("accumulator word not sign-extended");
    stall_hold_a: assert property (
        (issue_valid && op_w != IMAC_OP_NONE && rep_cnt_q != CNT_ZERO)
            |-> stall_req && !accept)
        else $error("busy unit took or did not stall an instruction");
    read_block_a: assert property (
        (read_req && any_busy) |=> !read_valid)
        else $error("accumulator read answered while busy");
    acc_reject_a: assert property (
        (opc_w == OPC_SPECIAL2 && fn_w == FN_SACC && dst_w != FIELD_ZERO)
            |-> !accept)
        else $error("accumulate with nonzero destination taken");
    acc_sum_a: assert property (
        (accept && op_w == IMAC_OP_SACC && sz_if.wide_cnt == 2'h0)
            |-> ##4 accumulator_bottom[WORD_W-1:0]
                == $past(acc_sum[WORD_W-1:0], 4))
        else $error("signed accumulate low word wrong");
endmodule : imac_unit
`default_nettype wire

// ===== imac_pipe_model.sv
// issue stage and register file model on the far side of the unit
`timescale 1ns/1ns
`default_nettype none
module imac_pipe_model
    import imac_pkg::*;
(
    input  wire logic             clk_sys,            // core clock
    input  wire logic             nrst,               // reset, low
    input  wire logic             issue_ready,        // op taken
    input  wire logic             stall_req,          // hold request
    input  wire logic             gpr_we,             // write pulse
    input  wire logic [REG_W-1:0] gpr_waddr,          // write index
    input  wire logic [XLEN-1:0]  gpr_wdata,          // write value
    input  wire logic [XLEN-1:0]  accumulator_bottom, // lower acc
    output logic                  issue_valid,        // op offered
    output logic [31:0]           issue_instr,        // op word
    output logic [XLEN-1:0]       src_a_data,         // source a
    output logic [XLEN-1:0]       src_b_data          // source b
);
    logic [159:0]    q[$];
    logic [XLEN-1:0] rf[32];
    logic [XLEN-1:0] acc_seen;
    int              cyc = 0;
    int              t_take = 0;
    int              t_prev = 0;
    int              t_wr = 0;
    int              t_acc = 0;
    int              n_wr = 0;
    int              n_stall = 0;

    task automatic push(input logic [31:0] w, input logic [XLEN-1:0] a, b);
        q.push_back({w, a, b});
    endtask : push

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            issue_valid <= 1'b0;
            issue_instr <= 32'h0;
            src_a_data <= 64'h0;
            src_b_data <= 64'h0;
        end else begin
            cyc <= cyc + 1;
            if (gpr_we) begin
                rf[gpr_waddr] <= gpr_wdata;
                t_wr <= cyc;
                n_wr <= n_wr + 1;
            end
            if (accumulator_bottom !== acc_seen) t_acc <= cyc;
            acc_seen <= accumulator_bottom;
            if (issue_valid && !issue_ready && stall_req) begin
                n_stall <= n_stall + 1;
            end
            if (issue_valid && issue_ready) begin
                t_prev <= t_take;
                t_take <= cyc;
            end
            // an op the unit neither takes nor stalls belongs elsewhere
            if (!issue_valid || issue_ready || !stall_req) begin
                if (q.size() > 0) begin
                    {issue_instr, src_a_data, src_b_data} <= q.pop_front();
                    issue_valid <= 1'b1;
                end else begin
                    // released lines must not keep showing the old word
                    issue_valid <= 1'b0;
                    issue_instr <= ~issue_instr;
                    src_a_data <= ~src_a_data;
                    src_b_data <= ~src_b_data;
                end
            end
        end
    end
endmodule : imac_pipe_model
`default_nettype wire

// ===== integer_multiply_accumulate_unit_bench.sv
// self-checking bench for the multiply-accumulate unit
`timescale 1ns/1ns
`default_nettype none
module integer_multiply_accumulate_unit_bench;
    import imac_pkg::*;
    logic             clk_sys = 1'b0;
    logic             nrst = 1'b0;
    logic             rd_up = 1'b0;
    logic             rd_bot = 1'b0;
    logic             iv, ir, sr, we, rr, rv;
    logic [31:0]      ins;
    logic [REG_W-1:0] wa;
    logic [XLEN-1:0]  opa, opb, wd, au, ab, rdat;
    logic [XLEN-1:0]  exp_up = 64'h0;
    logic [XLEN-1:0]  exp_bot = 64'h0;
    int               num_errors = 0;
    int               samples_checked = 0;
    int               cycles = 0;

    imac_unit i_dut (.clk_sys(clk_sys), .nrst(nrst), .issue_valid(iv),
        .issue_instr(ins), .src_a_data(opa), .src_b_data(opb),
        .issue_ready(ir), .stall_req(sr), .gpr_we(we), .gpr_waddr(wa),
        .gpr_wdata(wd), .accumulator_upper(au), .accumulator_bottom(ab),
        .read_upper_accumulator(rd_up), .read_lower_accumulator(rd_bot),
        .read_ready(rr), .read_valid(rv), .read_data(rdat));
    imac_pipe_model i_mdl (.clk_sys(clk_sys), .nrst(nrst),
        .issue_ready(ir), .stall_req(sr), .gpr_we(we), .gpr_waddr(wa),
        .gpr_wdata(wd), .accumulator_bottom(ab), .issue_valid(iv),
        .issue_instr(ins), .src_a_data(opa), .src_b_data(opb));

    always #10 clk_sys = ~clk_sys;

    task automatic tally_and_finish();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // generous ceiling: the whole sequence needs under two hundred cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    function automatic logic [XLEN-1:0] sx(input logic [31:0] w);
        return {{32{w[31]}}, w};
    endfunction : sx

    function automatic logic [31:0] mk(input logic [5:0] op,
        input logic [4:0] d, sh, input logic [5:0] fn);
        return {op, 5'h03, 5'h04, d, sh, fn};
    endfunction : mk

    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk

    // extra cycles after idle: results land after the in-flight flag drops
    task automatic settle();
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_sys);
            if (i_mdl.q.size() == 0 && iv === 1'b0 && rr === 1'b1) break;
        end
        repeat (3) @(negedge clk_sys);
    endtask : settle

    task automatic acc_step(input logic [5:0] fn, input logic [31:0] a, b);
        logic [63:0] s;
        s = {exp_up[31:0], exp_bot[31:0]} + (fn == FN_UACC ?
            {32'h0, a} * {32'h0, b} : sx(a) * sx(b));
        exp_up = sx(s[63:32]);
        exp_bot = sx(s[31:0]);
        i_mdl.push(mk(OPC_SPECIAL2, FIELD_ZERO, FIELD_ZERO, fn), sx(a), sx(b));
    endtask : acc_step

    task automatic t_acc(input logic [5:0] fn, input logic [31:0] a, b,
        input int lat);
        @(negedge clk_sys);
        acc_step(fn, a, b);
        acc_step(fn, a, b);
        settle();
        chk(i_mdl.t_take - i_mdl.t_prev == lat, "acc repeat");
        chk(i_mdl.t_acc - i_mdl.t_take == lat, "acc latency");
        chk(au === exp_up && ab === exp_bot, "acc value");
    endtask : t_acc

    task automatic t_read(input logic up, low);
        int w;
        @(negedge clk_sys);
        acc_step(FN_SACC, 32'h7, 32'hFFFFFFF7);
        repeat (2) @(posedge clk_sys);
        rd_up <= up;
        rd_bot <= low;
        @(negedge clk_sys);
        for (w = 0; w < 20 && rr !== 1'b1; w++) begin
            chk(sr === 1'b1, "read not stalled");
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        rd_up <= 1'b0;
        rd_bot <= 1'b0;
        #1;
        chk(w > 0 && rv === 1'b1, "read not interlocked");
        chk(rdat === (up ? exp_up : exp_bot), "read data");
        settle();
    endtask : t_read

    task automatic t_bad(input logic [31:0] w);
        int s0;
        int n0;
        s0 = i_mdl.n_stall;
        n0 = i_mdl.n_wr;
        @(negedge clk_sys);
        i_mdl.push(w, sx(32'h7), sx(32'h9));
        settle();
        chk(i_mdl.n_stall == s0 && i_mdl.n_wr == n0, "bad op acted");
        chk(au === exp_up && ab === exp_bot, "bad op changed acc");
    endtask : t_bad

    task automatic t_prod(input logic [31:0] a, b, input int lat);
        logic [63:0] p;
        int          s0;
        p = {32'h0, a} * {32'h0, b};
        s0 = i_mdl.n_stall;
        @(negedge clk_sys);
        i_mdl.push(mk(OPC_SPECIAL2, 5'h05, FIELD_ZERO, FN_PROD), sx(a), sx(b));
        i_mdl.push(mk(OPC_SPECIAL2, 5'h1F, FIELD_ZERO, FN_PROD), sx(b), sx(a));
        settle();
        chk(i_mdl.t_wr - i_mdl.t_take == lat, "prod latency");
        chk(i_mdl.t_take - i_mdl.t_prev == lat - 2, "prod repeat");
        chk(i_mdl.n_stall - s0 == lat - 3, "prod stalls");
        chk(i_mdl.rf[5] === sx(p[31:0]), "prod value");
        chk(i_mdl.rf[31] === sx(p[31:0]), "prod dest");
    endtask : t_prod

    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        t_acc(FN_SACC, 32'hFFFFFFFD, 32'h5, 4);
        t_acc(FN_SACC, 32'h00012345, 32'hFFFF8000, 5);
        t_acc(FN_UACC, 32'hFFFFFFFD, 32'h5, 5);
        t_acc(FN_UACC, 32'h0000F000, 32'h1234, 4);
        t_acc(FN_UACC, 32'h80000001, 32'h30000, 6);
        t_read(1'b0, 1'b1);
        t_read(1'b1, 1'b1);
        t_bad(mk(OPC_SPECIAL2, 5'h02, FIELD_ZERO, FN_SACC));
        t_bad(mk(OPC_SPECIAL2, FIELD_ZERO, 5'h01, FN_UACC));
        t_bad(mk(OPC_SPECIAL2, 5'h02, 5'h10, FN_PROD));
        t_bad(mk(6'h1D, FIELD_ZERO, FIELD_ZERO, FN_SACC));
        t_prod(32'h5, 32'hFFFFFFFD, 4);
        t_prod(32'h00012345, 32'h7, 5);
        t_prod(32'h00012345, 32'hFFFE0000, 6);
        tally_and_finish();
    end
endmodule : integer_multiply_accumulate_unit_bench
`default_nettype wire
